// ==== inc/acl_pkg.sv ====
// Shared constants, modes and carrier structs of the AC-link codec access block
package acl_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int ACL_CLK_NS = 5;
	localparam int ACL_LINK_NS = 125;
	localparam int ACL_HALF_CYC = ACL_LINK_NS / (2 * ACL_CLK_NS);

	// ------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------
	localparam logic [4:0] ACL_SLOT0_TOP = 5'h0F;
	localparam logic [4:0] ACL_SLOT_TOP = 5'h13;
	localparam logic [3:0] ACL_LAST_SLOT = 4'hC;
	localparam int ACL_TAG_FRAME = 15;
	localparam int ACL_TAG_S1 = 14;
	localparam int ACL_TAG_S2 = 13;
	localparam int ACL_TAG_S3 = 12;
	localparam int ACL_TAG_S4 = 11;
	localparam int ACL_TAG_S12 = 3;
	localparam int ACL_REQ_S3 = 11;
	localparam int ACL_REQ_S4 = 10;
	localparam logic [1:0] ACL_PRIMARY_ID = 2'h0;

	// ------------------------------------------------------------
	// Register indices, fields and reset values
	// ------------------------------------------------------------
	localparam logic [6:0] ACL_OFS_PDN = 7'h26;
	localparam logic [6:0] ACL_OFS_RISE_IRQ_ENABLE = 7'h5E;
	localparam logic [6:0] ACL_OFS_FALL_IRQ_ENABLE = 7'h60;
	localparam logic [6:0] ACL_OFS_IRQ_CLEAR_STATUS = 7'h62;
	localparam logic [6:0] ACL_OFS_FEATURE_ONE = 7'h6A;
	localparam logic [6:0] ACL_OFS_TEST_SELECTOR = 7'h6E;
	localparam int ACL_LINK_POWERDOWN_BIT = 12;
	localparam int ACL_SLOT_IRQ_FORWARD_ENABLE = 1;
	localparam logic [15:0] ACL_REG_RESET = 16'h0000;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {ACL_RUN, ACL_PDN, ACL_WARM, ACL_ICT} acl_mode_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [15:0] wdata;
	} acl_reg_req_s;

	typedef struct packed {
		logic valid;
		logic [19:0] left;
		logic [19:0] right;
	} acl_pcm_s;

	typedef struct packed {
		logic rec_var;
		logic play_var;
		logic play_need;
		logic play_pdn;
	} acl_rate_s;

	typedef struct packed {
		acl_mode_e mode;
		logic armed;
		logic vtest;
		logic oe_n;
		logic clk_lvl;
		logic sdi;
		logic sync_q;
		logic fstart;
		logic infrm;
		logic [3:0] slot;
		logic [4:0] sbit;
		logic [19:0] sh;
		logic [15:0] tag;
		logic [6:0] addr;
		logic rd_wait;
		logic pend;
		logic [15:0] rsp;
		logic [15:0] tx_tag;
		logic [19:0] tx_s1;
		logic [19:0] tx_s2;
		logic [19:0] tx_s3;
		logic [19:0] tx_s4;
		logic tx_gint;
		logic [15:0] pdn_reg;
		logic [15:0] rise_irq_enable_reg;
		logic [15:0] fall_irq_enable_reg;
		logic [15:0] feature_control_status_one_reg;
		logic [15:0] test_selector_reg;
		acl_reg_req_s req;
		logic [15:0] irq_clr;
		acl_pcm_s play;
		logic rec_take;
		logic irq;
		logic [15:0] tfunc;
	} acl_state_s;

endpackage

// ==== src/acl_sync2.sv ====
// Two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module acl_sync2 #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			meta_reg <= '0;
			o_q <= '0;
		end else begin
			meta_reg <= i_d;
			o_q <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ==== src/acl_bitclk.sv ====
// Divider making rise and fall enable pulses for the link bit clock
`timescale 1ns/1ps
`default_nettype none
module acl_bitclk #(
	parameter int HALF = acl_pkg::ACL_HALF_CYC
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_en,
	output logic o_rise,
	output logic o_fall
);
	logic [7:0] cnt_reg;
	logic hi_reg;

	// Stopped divider parks low so the first edge after restart is a rise
	always_ff @(posedge i_clk) begin
		if (i_srst || !i_en) begin
			cnt_reg <= 8'h00;
			hi_reg <= 1'b0;
			o_rise <= 1'b0;
			o_fall <= 1'b0;
		end else if (cnt_reg == 8'(HALF - 1)) begin
			cnt_reg <= 8'h00;
			hi_reg <= !hi_reg;
			o_rise <= !hi_reg;
			o_fall <= hi_reg;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
			o_rise <= 1'b0;
			o_fall <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== src/acl_codec_access.sv ====
// Codec-side AC-link access: slot 0 decode, register access, requests, power-down and test modes
//
// How it works
// - Slot 0 tags: frame, slot1, slot2, slots 3-12.
// - Act only on valid primary tagged accesses.
// - Read in frame N answered in N+1.
// - Write stored; next frame slot tags cleared.
// - Slot 1/2 tags only carry read data.
// - Request bits valid regardless of slot 1 tag.
// - Variable capture rate: slot 3/4 tag per sample.
// - Active-low requests at bits 11, 10 only.
// - Requests from rate, fill, power state each frame.
// - Power-down bit write halts bit clock, data.
// - Wake event raises interrupt pin while down.
// - Forwarded wake holds data high until sync pulse ends.
// - Data-out high at reset release: in-circuit test.
// - Sync high at reset release: vendor test.
// - In-circuit test floats bit clock and data.
// - Test selector picks the vendor test function.
// - Primary codec only, timing from local clock.
// - Launch on rising, sample on falling edge.
// - Warm reset: restart clock after sync low.
// - Input slots 5 to 11 stuffed with zero.
`timescale 1ns/1ps
`default_nettype none
module acl_codec_access #(
	parameter int HALF = acl_pkg::ACL_HALF_CYC
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_sync,
	input wire logic i_sdata_out,
	input wire logic [15:0] i_irq_status,
	input wire acl_pkg::acl_rate_s i_rate,
	input wire acl_pkg::acl_pcm_s i_rec,
	input wire logic [15:0] i_reg_rdata,
	output logic o_bit_clk,
	output logic o_bit_clk_oe_n,
	output logic o_sdata_in,
	output logic o_sdata_in_oe_n,
	output logic o_interrupt_output_pin,
	output acl_pkg::acl_reg_req_s o_reg,
	output logic [15:0] o_irq_clear,
	output acl_pkg::acl_pcm_s o_play,
	output logic o_rec_take,
	output logic [15:0] o_test_func
);
	acl_pkg::acl_state_s s_reg;
	acl_pkg::acl_state_s s_next;
	logic sync_s;
	logic sdo_s;
	logic [15:0] irq_s;
	logic rise;
	logic fall;

	// ------------------------------------------------------------
	// Pin synchronisers and bit clock divider
	// ------------------------------------------------------------
	acl_sync2 #(.W(18)) u_sync (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_d({i_sync, i_sdata_out, i_irq_status}),
		.o_q({sync_s, sdo_s, irq_s})
	);

	// Bit clock made from the local clock, never taken from the controller
	acl_bitclk #(.HALF(HALF)) u_div (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_en(s_reg.mode == acl_pkg::ACL_RUN && s_reg.armed),
		.o_rise(rise),
		.o_fall(fall)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic tx_bit(acl_pkg::acl_state_s s);
		case (s.slot)
			4'h0: tx_bit = s.tx_tag[s.sbit[3:0]];
			4'h1: tx_bit = s.tx_s1[s.sbit];
			4'h2: tx_bit = s.tx_s2[s.sbit];
			4'h3: tx_bit = s.tx_s3[s.sbit];
			4'h4: tx_bit = s.tx_s4[s.sbit];
			4'hC: tx_bit = s.tx_gint && s.sbit == 5'h00;
			default: tx_bit = 1'b0;
		endcase
	endfunction

	function automatic logic [15:0] reg_read(acl_pkg::acl_state_s s, logic [15:0] st, logic [15:0] ext);
		case (s.req.addr)
			acl_pkg::ACL_OFS_PDN: reg_read = s.pdn_reg;
			acl_pkg::ACL_OFS_RISE_IRQ_ENABLE: reg_read = s.rise_irq_enable_reg;
			acl_pkg::ACL_OFS_FALL_IRQ_ENABLE: reg_read = s.fall_irq_enable_reg;
			acl_pkg::ACL_OFS_IRQ_CLEAR_STATUS: reg_read = st;
			acl_pkg::ACL_OFS_FEATURE_ONE: reg_read = s.feature_control_status_one_reg;
			acl_pkg::ACL_OFS_TEST_SELECTOR: reg_read = s.test_selector_reg;
			default: reg_read = ext;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [19:0] w;
		logic prim;
		logic slot_irq_forward_enable;
		logic req3;
		logic req4;
		w = {s_reg.sh[18:0], sdo_s};
		slot_irq_forward_enable = s_reg.feature_control_status_one_reg[acl_pkg::ACL_SLOT_IRQ_FORWARD_ENABLE];
		prim = s_reg.tag[acl_pkg::ACL_TAG_FRAME] && s_reg.tag[acl_pkg::ACL_TAG_S1]
			&& s_reg.tag[1:0] == acl_pkg::ACL_PRIMARY_ID;
		req3 = !i_rate.play_pdn && (!i_rate.play_var || i_rate.play_need);
		req4 = req3;
		s_next = s_reg;
		s_next.req.wr = 1'b0;
		s_next.req.rd = 1'b0;
		s_next.irq_clr = 16'h0000;
		s_next.play.valid = 1'b0;
		s_next.rec_take = 1'b0;
		s_next.fstart = 1'b0;
		s_next.irq = |irq_s;
		s_next.tfunc = s_reg.vtest ? s_reg.test_selector_reg : 16'h0000;
		// Reset clears the pin synchronisers too: wait until the straps have passed them
		if (!s_reg.armed) begin
			s_next.sbit = s_reg.sbit + 5'h01;
			if (s_reg.sbit == 5'h02) begin
				s_next.armed = 1'b1;
				s_next.mode = sdo_s ? acl_pkg::ACL_ICT : acl_pkg::ACL_RUN;
				s_next.vtest = sync_s;
			end
		end
		if (s_reg.rd_wait) begin
			s_next.rd_wait = 1'b0;
			s_next.rsp = reg_read(s_reg, irq_s, i_reg_rdata);
			s_next.pend = 1'b1;
		end
		case (s_reg.mode)
			acl_pkg::ACL_ICT: begin
				// Held until cold reset
				s_next.clk_lvl = 1'b0;
			end
			acl_pkg::ACL_PDN: begin
				s_next.clk_lvl = 1'b0;
				if (slot_irq_forward_enable && |irq_s) begin
					s_next.sdi = 1'b1;
				end
				if (sync_s) begin
					s_next.mode = acl_pkg::ACL_WARM;
				end
			end
			acl_pkg::ACL_WARM: begin
				// No restart while sync is high: avoids a false frame start
				if (!sync_s) begin
					s_next.mode = acl_pkg::ACL_RUN;
					s_next.sdi = 1'b0;
					s_next.sync_q = 1'b0;
				end
			end
			acl_pkg::ACL_RUN: begin
				if (rise && s_reg.armed) begin
					s_next.clk_lvl = 1'b1;
					s_next.sdi = s_reg.infrm ? tx_bit(s_reg) : 1'b0;
				end
				if (fall && s_reg.armed) begin
					s_next.clk_lvl = 1'b0;
					s_next.sync_q = sync_s;
					s_next.sh = w;
					if (sync_s && !s_reg.sync_q) begin
						s_next.fstart = 1'b1;
						s_next.infrm = 1'b1;
						s_next.slot = 4'h0;
						s_next.sbit = acl_pkg::ACL_SLOT0_TOP;
						s_next.pend = 1'b0;
						s_next.tx_tag = {1'b1, s_reg.pend, s_reg.pend,
							!i_rate.rec_var || i_rec.valid, !i_rate.rec_var || i_rec.valid,
							7'h00, slot_irq_forward_enable, 3'h0};
						s_next.tx_s1 = {1'b0, s_reg.pend ? s_reg.req.addr : 7'h00,
							!req3, !req4, 8'h00, 2'h0};
						s_next.tx_s2 = {s_reg.pend ? s_reg.rsp : 16'h0000, 4'h0};
						s_next.tx_gint = slot_irq_forward_enable && |irq_s;
						s_next.rec_take = i_rec.valid;
						if (i_rec.valid) begin
							s_next.tx_s3 = i_rec.left;
							s_next.tx_s4 = i_rec.right;
						end
					end else if (s_reg.infrm) begin
						if (s_reg.sbit == 5'h00) begin
							s_next.sbit = acl_pkg::ACL_SLOT_TOP;
							s_next.slot = s_reg.slot + 4'h1;
							s_next.infrm = s_reg.slot != acl_pkg::ACL_LAST_SLOT;
							case (s_reg.slot)
								4'h0: s_next.tag = w[15:0];
								4'h1: s_next.addr = w[18:12];
								4'h2: begin
									if (prim && s_reg.tag[acl_pkg::ACL_TAG_S2]) begin
										s_next.req.wr = 1'b1;
										s_next.req.addr = s_reg.addr;
										s_next.req.wdata = w[19:4];
										case (s_reg.addr)
											acl_pkg::ACL_OFS_PDN: begin
												s_next.pdn_reg = w[19:4];
												if (w[4 + acl_pkg::ACL_LINK_POWERDOWN_BIT]) begin
													s_next.mode = acl_pkg::ACL_PDN;
													s_next.clk_lvl = 1'b0;
													s_next.sdi = 1'b0;
													s_next.infrm = 1'b0;
												end
											end
											acl_pkg::ACL_OFS_RISE_IRQ_ENABLE: s_next.rise_irq_enable_reg = w[19:4];
											acl_pkg::ACL_OFS_FALL_IRQ_ENABLE: s_next.fall_irq_enable_reg = w[19:4];
											acl_pkg::ACL_OFS_IRQ_CLEAR_STATUS: s_next.irq_clr = w[19:4];
											acl_pkg::ACL_OFS_FEATURE_ONE: s_next.feature_control_status_one_reg = w[19:4];
											acl_pkg::ACL_OFS_TEST_SELECTOR: s_next.test_selector_reg = w[19:4];
											default: s_next.req.wr = 1'b1;
										endcase
									end else if (prim) begin
										s_next.req.rd = 1'b1;
										s_next.req.addr = s_reg.addr;
										s_next.rd_wait = 1'b1;
									end
								end
								4'h3: s_next.play.left = w;
								4'h4: begin
									s_next.play.right = w;
									s_next.play.valid = s_reg.tag[acl_pkg::ACL_TAG_S3]
										|| s_reg.tag[acl_pkg::ACL_TAG_S4];
								end
								default: s_next.sh = w;
							endcase
						end else begin
							s_next.sbit = s_reg.sbit - 5'h01;
						end
					end
				end
			end
			default: s_next.mode = acl_pkg::ACL_RUN;
		endcase
		s_next.oe_n = s_next.mode == acl_pkg::ACL_ICT;
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_bit_clk = s_reg.clk_lvl;
	assign o_bit_clk_oe_n = s_reg.oe_n;
	assign o_sdata_in = s_reg.sdi;
	assign o_sdata_in_oe_n = s_reg.oe_n;
	assign o_interrupt_output_pin = s_reg.irq;
	assign o_reg = s_reg.req;
	assign o_irq_clear = s_reg.irq_clr;
	assign o_play = s_reg.play;
	assign o_rec_take = s_reg.rec_take;
	assign o_test_func = s_reg.tfunc;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);

	sequence seq_warm_exit;
		s_reg.mode == acl_pkg::ACL_WARM ##1 s_reg.mode == acl_pkg::ACL_RUN;
	endsequence

	sequence seq_pdn_write;
		s_reg.req.wr && s_reg.req.addr == acl_pkg::ACL_OFS_PDN
			&& s_reg.req.wdata[acl_pkg::ACL_LINK_POWERDOWN_BIT];
	endsequence

	chk_cmd_primary: assert property ((s_reg.req.wr || s_reg.req.rd) |-> s_reg.tag[1:0] == 2'b00
		&& s_reg.tag[15] && s_reg.tag[14])
		else $error("command taken from a non-primary frame");
	chk_rd_answer: assert property (s_reg.req.rd |=> s_reg.pend)
		else $error("read not answered");
	chk_wr_silent: assert property (s_reg.req.wr |=> !s_reg.pend)
		else $error("write produced a response");
	chk_resp_tags: assert property (s_reg.fstart |-> s_reg.tx_tag[14] == $past(s_reg.pend)
		&& s_reg.tx_tag[13] == $past(s_reg.pend))
		else $error("slot 1/2 tags not tied to read data");
	chk_rec_tag: assert property (s_reg.fstart && $past(i_rate.rec_var) |->
		s_reg.tx_tag[12] == $past(i_rec.valid))
		else $error("slot 3 tag wrong at variable rate");
	chk_req_stuff: assert property (s_reg.fstart |-> s_reg.tx_s1[9:0] == 10'h000 && !s_reg.tx_s1[19])
		else $error("unused request bits not zero");
	chk_pdn_halt: assert property (seq_pdn_write |-> (s_reg.mode == acl_pkg::ACL_PDN
		&& !s_reg.clk_lvl)[*3])
		else $error("link not halted after power-down write");
	chk_irq_pin: assert property (s_reg.mode == acl_pkg::ACL_PDN && |irq_s |=> s_reg.irq)
		else $error("wake did not raise interrupt pin");
	chk_wake_sdi: assert property (s_reg.mode == acl_pkg::ACL_PDN && |irq_s
		&& s_reg.feature_control_status_one_reg[acl_pkg::ACL_SLOT_IRQ_FORWARD_ENABLE] |=> s_reg.sdi)
		else $error("forwarded wake not on data line");
	chk_warm_gate: assert property (seq_warm_exit |-> !$past(sync_s))
		else $error("clock restarted with sync high");
	chk_ict_float: assert property ($rose(s_reg.armed) |-> s_reg.oe_n == $past(sdo_s)
		&& s_reg.vtest == $past(sync_s))
		else $error("test strap not honoured");
	chk_test_func: assert property (s_reg.vtest |=> s_reg.tfunc == $past(s_reg.test_selector_reg))
		else $error("test function not from selector");
endmodule
`default_nettype wire

// ==== dv/acl_ctrl_model.sv ====
// Controller-side link model: sends output frames and captures input frames
`timescale 1ns/1ps
`default_nettype none
module acl_ctrl_model (
	input wire logic i_clk,
	input wire logic i_bit_clk,
	input wire logic i_sdata_in,
	output logic o_sync,
	output logic o_sdata_out
);
	initial begin
		o_sync = 1'b0;
		o_sdata_out = 1'b0;
	end

	task automatic pins(input logic s, input logic d);
		o_sync = s;
		o_sdata_out = d;
	endtask

	// Edge finder; the bit clock is only seen through the system clock
	task automatic edge_wait(input logic lvl);
		logic prev;
		prev = i_bit_clk;
		@(negedge i_clk);
		while (i_bit_clk !== lvl || prev === lvl) begin
			prev = i_bit_clk;
			@(negedge i_clk);
		end
	endtask

	// First n bits of a frame, MSB first; short frames are for a halting write
	task automatic xfer(input logic [255:0] fo, input int n, output logic [255:0] fi);
		fi = '0;
		edge_wait(1'b1);
		o_sync = 1'b1;
		for (int j = 255; j > 255 - n; j--) begin
			edge_wait(1'b1);
			o_sdata_out = fo[j];
			if (j == 240)
				o_sync = 1'b0;
			edge_wait(1'b0);
			fi[j] = i_sdata_in;
		end
		o_sdata_out = 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== dv/aclink_codec_access_test.sv ====
// Self-checking bench: register access, requests, power-down, wake and test modes over the link
`timescale 1ns/1ps
`default_nettype none
module aclink_codec_access_test;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic [15:0] irq = 16'h0000;
	acl_pkg::acl_rate_s rate = '0;
	acl_pkg::acl_pcm_s rec = '0;
	logic [15:0] rdata = 16'h0000;
	logic bclk, bclk_oe_n, sdi, sdi_oe_n, irq_pin, take, sync, sdo;
	logic [15:0] clr, tfunc;
	logic [15:0] clr_seen = 16'h0000;
	acl_pkg::acl_reg_req_s oreg;
	acl_pkg::acl_pcm_s play;
	acl_pkg::acl_pcm_s play_seen = '0;
	acl_pkg::acl_reg_req_s wr_seen = '0;
	logic [255:0] fi;
	logic [3:0] rtab [4] = '{4'h0, 4'h1, 4'hE, 4'hC};
	logic [1:0] rq [4] = '{2'h0, 2'h3, 2'h0, 2'h3};
	logic [1:0] rt [4] = '{2'h3, 2'h3, 2'h3, 2'h0};
	int error_cnt = 0;
	int checks = 0;
	int cyc = 0;
	wire bclk_w;
	wire sdi_w;

	// Wire level from the enables; floats in the in-circuit test
	assign bclk_w = bclk_oe_n ? 1'bz : bclk;
	assign sdi_w = sdi_oe_n ? 1'bz : sdi;

	acl_codec_access #(.HALF(4)) dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_sync(sync), .i_sdata_out(sdo),
		.i_irq_status(irq), .i_rate(rate), .i_rec(rec), .i_reg_rdata(rdata), .o_bit_clk(bclk),
		.o_bit_clk_oe_n(bclk_oe_n), .o_sdata_in(sdi), .o_sdata_in_oe_n(sdi_oe_n), .o_interrupt_output_pin(irq_pin),
		.o_reg(oreg), .o_irq_clear(clr), .o_play(play), .o_rec_take(take), .o_test_func(tfunc));
	acl_ctrl_model ctrl_u (.i_clk(i_clk), .i_bit_clk(bclk_w), .i_sdata_in(sdi_w), .o_sync(sync), .o_sdata_out(sdo));

	always #2.5 i_clk = ~i_clk;

	// Outside register file answers with a pattern made from the index
	always @(negedge i_clk) begin
		rdata <= {1'b1, oreg.addr, 1'b0, ~oreg.addr};
		if (take === 1'b1)
			rec.valid <= 1'b0;
	end

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (play.valid === 1'b1)
			play_seen <= play;
		if (oreg.wr === 1'b1)
			wr_seen <= oreg;
		if (clr !== 16'h0000)
			clr_seen <= clr;
		if (cyc == 80000) begin
			error_cnt++;
			end_of_test();
		end
	end

	// ------------------------------------------------------------
	// Link access tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Tags are {frame, slot 1, slot 2, slot 3, slot 4}
	task automatic io(input logic [4:0] t, input logic [1:0] id, input logic [6:0] a, input logic [15:0] d,
		input logic [39:0] pcm, input int n = 256);
		logic [255:0] f;
		f = '0;
		f[255:251] = t;
		f[241:240] = id;
		f[238:232] = a;
		f[219:204] = d;
		f[199:160] = pcm;
		ctrl_u.xfer(f, n, fi);
	endtask

	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		io(5'h1C, 2'h0, a, d, 40'h0);
	endtask

	task automatic idle();
		io(5'h10, 2'h0, 7'h00, 16'h0000, 40'h0);
	endtask

	// Junk in slot 2 of a read must not matter; the answer comes a frame later
	task automatic rd(input logic [6:0] a, input logic [15:0] exp);
		io(5'h18, 2'h0, a, 16'hBEEF, 40'h0);
		idle();
		chk("read tags", 2'h3, fi[254:253]);
		chk("read index", a, fi[238:232]);
		chk("read data", exp, fi[219:204]);
	endtask

	task automatic hold(input string what, input int n, input logic b, input logic s);
		logic good;
		good = 1'b1;
		repeat (n) begin
			@(negedge i_clk);
			if (bclk !== b || sdi !== s)
				good = 1'b0;
		end
		chk(what, 1'b1, good);
	endtask

	task automatic cold(input logic s, input logic d);
		i_srst = 1'b1;
		ctrl_u.pins(s, d);
		repeat (12) @(negedge i_clk);
		i_srst = 1'b0;
		repeat (3) @(negedge i_clk);
		ctrl_u.pins(1'b0, 1'b0);
	endtask

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		cold(1'b0, 1'b0);
		wr(acl_pkg::ACL_OFS_RISE_IRQ_ENABLE, 16'hA55A);
		idle();
		chk("write tags", 2'h0, fi[254:253]);
		chk("write request", {2'h2, acl_pkg::ACL_OFS_RISE_IRQ_ENABLE, 16'hA55A}, wr_seen);
		chk("codec ready", 1'b1, fi[255]);
		chk("stuffing", 1'b0, |{fi[239], fi[229:220], fi[203:200], fi[159:20]});
		rd(acl_pkg::ACL_OFS_RISE_IRQ_ENABLE, 16'hA55A);
		rd(7'h02, {1'b1, 7'h02, 1'b0, 7'h7D});
		for (int k = 1; k < 5; k++) begin
			io({k < 4, 4'h8}, k[1:0], acl_pkg::ACL_OFS_RISE_IRQ_ENABLE, 16'h0000, 40'h0);
			idle();
			chk("ignored tags", 2'h0, fi[254:253]);
		end
		// Slot 1 untagged on purpose: requests still count
		for (int k = 0; k < 4; k++) begin
			rate = rtab[k];
			if (k == 2)
				rec = {1'b1, 40'h12345_6789A};
			io(5'h13, 2'h0, 7'h00, 16'h0000, 40'hABCDE_54321);
			chk("request bits", rq[k], fi[231:230]);
			chk("record tags", rt[k], fi[252:251]);
			if (k == 2)
				chk("record slots", 40'h12345_6789A, fi[199:160]);
		end
		chk("play data", 40'hABCDE_54321, play_seen[39:0]);
		wr(acl_pkg::ACL_OFS_RISE_IRQ_ENABLE, 16'h0010);
		wr(acl_pkg::ACL_OFS_FALL_IRQ_ENABLE, 16'h0010);
		wr(acl_pkg::ACL_OFS_IRQ_CLEAR_STATUS, 16'hFFFF);
		wr(acl_pkg::ACL_OFS_FEATURE_ONE, 16'h0002);
		irq = 16'h0004;
		idle();
		chk("clear pulse", 16'hFFFF, clr_seen);
		chk("forwarded irq", 2'h3, {fi[243], fi[0]});
		chk("irq pin", 1'b1, irq_pin);
		irq = 16'h0000;
		io(5'h1C, 2'h0, acl_pkg::ACL_OFS_PDN, 16'h1000, 40'h0, 56);
		hold("halted link", 100, 1'b0, 1'b0);
		irq = 16'h0010;
		repeat (8) @(negedge i_clk);
		chk("wake pin", 1'b1, irq_pin);
		ctrl_u.pins(1'b1, 1'b0);
		hold("warm reset hold", 200, 1'b0, 1'b1);
		ctrl_u.pins(1'b0, 1'b0);
		irq = 16'h0000;
		repeat (10) @(negedge i_clk);
		chk("wake data released", 1'b0, sdi);
		rd(acl_pkg::ACL_OFS_RISE_IRQ_ENABLE, 16'h0010);
		cold(1'b0, 1'b1);
		chk("float enables", 2'h3, {bclk_oe_n, sdi_oe_n});
		cold(1'b1, 1'b0);
		wr(acl_pkg::ACL_OFS_TEST_SELECTOR, 16'h00C3);
		repeat (4) @(negedge i_clk);
		chk("test function", 16'h00C3, tfunc);
		cold(1'b0, 1'b0);
		chk("normal after cold", 17'h0, {tfunc, bclk_oe_n});
		end_of_test();
	end
endmodule
`default_nettype wire
